// file: rtl/psp_pkg.sv
/*
  constants shared by the pwm duty stepper positioner: widths, counts,
  coil patterns and state encodings.
  assumes a single 40 MHz system clock and an active-low async reset.
*/
package psp_pkg;

  localparam int unsigned CNT_W      = 24;             // edge capture counter width
  localparam int unsigned POS_W      = 7;              // position 0..100
  localparam int unsigned PCT_W      = 7;              // width of the factor 100
  localparam int unsigned NUM_W      = CNT_W + PCT_W;  // width of high time * 100
  localparam int unsigned HOLD_W     = 16;             // hold time input width
  localparam int unsigned IDX_W      = 2;              // coil sequence index width

  localparam logic [PCT_W-1:0]  PCT_SCALE   = 7'h64;   // 100 percent
  localparam logic [POS_W-1:0]  POS_MAX     = 7'h64;   // highest legal position
  localparam logic [POS_W-1:0]  HOME_STEPS  = 7'h64;   // backward steps after reset
  localparam logic [POS_W-1:0]  START_POS   = 7'h00;   // position at the stop
  localparam logic [CNT_W-1:0]  CNT_ZERO    = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 24'hFFFFFF;
  localparam logic [HOLD_W-1:0] HOLD_MIN    = 16'h0001;
  localparam logic [IDX_W-1:0]  IDX_RESET   = 2'h0;

  // coil patterns along the forward walk; backward walks the index down
  localparam logic [3:0] COIL_PAT0 = 4'hA;
  localparam logic [3:0] COIL_PAT1 = 4'h9;
  localparam logic [3:0] COIL_PAT2 = 4'h5;
  localparam logic [3:0] COIL_PAT3 = 4'h6;

  // coil port bit positions
  localparam int unsigned BIT_A_POS = 0;
  localparam int unsigned BIT_A_NEG = 1;
  localparam int unsigned BIT_B_POS = 2;
  localparam int unsigned BIT_B_NEG = 3;

  // measurement states, gray along the usual path
  typedef enum logic [1:0] {
    PSP_M_FIRST  = 2'b00,
    PSP_M_SECOND = 2'b01,
    PSP_M_FALL   = 2'b11,
    PSP_M_DIVIDE = 2'b10
  } psp_meas_e;

  // motor states
  typedef enum logic [1:0] {
    PSP_S_HOME = 2'b00,
    PSP_S_IDLE = 2'b01,
    PSP_S_FWD  = 2'b11,
    PSP_S_BWD  = 2'b10
  } psp_motor_e;

endpackage

// file: rtl/psp_divider.sv
/*
  iterative restoring divider, one quotient bit per clock.
  assumes the caller never starts it with a zero divisor.
*/
module psp_divider #(
  parameter int unsigned DW = 31,
  parameter int unsigned VW = 24
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // request
  input  wire logic          start,
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  // answer
  output logic               busy,
  output logic               done,
  output logic      [DW-1:0] quotient
);

  localparam logic [5:0] BITS = 6'(DW);

  logic [VW:0]  rem;
  logic [5:0]   left;
  logic [VW:0]  shifted;

  // remainder shifted left by one with the next dividend bit
  always_comb begin
    shifted = {rem[VW-1:0], quotient[DW-1]};
  end

  // one restoring step per clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rem      <= '0;
      quotient <= '0;
      left     <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem      <= '0;
        quotient <= dividend;
        left     <= BITS;
        busy     <= 1'b1;
      end else if (busy) begin
        if (shifted >= {1'b0, divisor}) begin
          rem      <= shifted - {1'b0, divisor};
          quotient <= {quotient[DW-2:0], 1'b1};
        end else begin
          rem      <= shifted;
          quotient <= {quotient[DW-2:0], 1'b0};
        end
        left <= left - 6'h01;
        if (left == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// file: rtl/psp_positioner.sv
/*
  pwm duty stepper positioner: measures period and high time of the pwm
  on capture_pin, turns the duty into a position 0..100 and steps a
  bipolar stepper toward it through four directly driven coil outputs.
  assumes capture_pin is asynchronous; step_hold is quasi-static.
*/
module psp_positioner
  import psp_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // pwm input pin
  input  wire logic                        capture_pin,
  // settle time between coil pattern changes, in clock cycles
  input  wire logic [psp_pkg::HOLD_W-1:0]  step_hold,
  // coil terminals, port bits 0 to 3
  output logic                             winding_a_pos,
  output logic                             winding_a_neg,
  output logic                             winding_b_pos,
  output logic                             winding_b_neg,
  // status
  output logic [psp_pkg::POS_W-1:0]        current_position,
  output logic [psp_pkg::POS_W-1:0]        required_position,
  output logic [psp_pkg::CNT_W-1:0]        period_value,
  output logic [psp_pkg::CNT_W-1:0]        high_value,
  output logic                             homing_done,
  output logic                             duty_valid
);
  import psp_pkg::*;

  psp_meas_e          meas_state;
  psp_motor_e         motor_state;
  logic               cap_meta;
  logic               cap_sync;
  logic               cap_prev;
  logic [2:0]         cap_arm;
  logic               edge_rise;
  logic               edge_fall;
  logic [CNT_W-1:0]   edge_cnt;
  logic               cnt_full;
  logic               div_start;
  logic               div_busy;
  logic               div_done;
  logic [NUM_W-1:0]   div_quot;
  logic [NUM_W-1:0]   div_num;
  logic [HOLD_W-1:0]  hold_cnt;
  logic               hold_over;
  logic [POS_W-1:0]   home_left;
  logic [IDX_W-1:0]   coil_idx;
  logic [3:0]         coil_port;
  logic [3:0]         next_pattern;
  logic               step_fwd;
  logic               step_bwd;

  // two-stage synchroniser, then an edge detector on the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      cap_prev <= 1'b0;
      cap_arm  <= 3'h0;
    end else begin
      cap_meta <= capture_pin;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
      cap_arm  <= {cap_arm[1:0], 1'b1};  // fills once three clocks have passed
    end
  end

  // both edges of the one capture input feed the measurement
  // edges count only once both stages hold real pin samples, so a pin
  // already high at reset release is not taken for a rising edge
  assign edge_rise = cap_sync & ~cap_prev & cap_arm[2];
  assign edge_fall = ~cap_sync & cap_prev & cap_arm[2];
  assign cnt_full  = (edge_cnt == CNT_MAX);

  // free capture counter, cleared at points one and two, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= CNT_ZERO;
    end else if (edge_rise && meas_state != PSP_M_FALL) begin
      edge_cnt <= CNT_ZERO;
    end else if (!cnt_full) begin
      edge_cnt <= edge_cnt + 24'h000001;
    end
  end

  // high time times 100 as dividend
  assign div_num = NUM_W'(high_value) * NUM_W'(PCT_SCALE);

  // measurement sequence: rising, rising, falling, divide
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meas_state   <= PSP_M_FIRST;
      period_value <= CNT_ZERO;
      high_value   <= CNT_ZERO;
      div_start    <= 1'b0;
    end else begin
      div_start <= 1'b0;
      case (meas_state)
        PSP_M_FIRST: begin
          if (edge_rise) begin
            meas_state <= PSP_M_SECOND;
          end
        end
        PSP_M_SECOND: begin
          if (edge_rise) begin
            period_value <= edge_cnt;
            meas_state   <= PSP_M_FALL;
          end else if (cnt_full) begin
            meas_state <= PSP_M_FIRST;  // input stuck, restart
          end
        end
        PSP_M_FALL: begin
          if (edge_fall) begin
            high_value <= edge_cnt;
            if (period_value != CNT_ZERO) begin
              div_start  <= 1'b1;
              meas_state <= PSP_M_DIVIDE;
            end else begin
              meas_state <= PSP_M_FIRST;
            end
          end else if (cnt_full) begin
            meas_state <= PSP_M_FIRST;
          end
        end
        PSP_M_DIVIDE: begin
          if (div_done) begin
            meas_state <= PSP_M_FIRST;
          end
        end
        default: begin
          meas_state <= PSP_M_FIRST;
        end
      endcase
    end
  end

  psp_divider #(
    .DW (NUM_W),
    .VW (CNT_W)
  ) u_divider (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (div_start),
    .dividend (div_num),
    .divisor  (period_value),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

  // accept a fresh duty only inside 0..100, otherwise keep the old target
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      required_position <= START_POS;
      duty_valid        <= 1'b0;
    end else if (div_done && !div_busy) begin
      if (div_quot <= NUM_W'(POS_MAX)) begin
        required_position <= div_quot[POS_W-1:0];
        duty_valid        <= 1'b1;
      end
    end
  end

  // hold timer: a step may only be taken once it has run out
  assign hold_over = (hold_cnt == '0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
    end else if (step_fwd || step_bwd) begin
      hold_cnt <= (step_hold < HOLD_MIN) ? '0 : step_hold - HOLD_MIN;
    end else if (!hold_over) begin
      hold_cnt <= hold_cnt - HOLD_MIN;
    end
  end

  // direction decision, one step per hold period
  always_comb begin
    step_fwd = 1'b0;
    step_bwd = 1'b0;
    case (motor_state)
      PSP_S_HOME: begin
        step_bwd = hold_over && (home_left != START_POS);
      end
      PSP_S_FWD: begin
        step_fwd = hold_over;
      end
      PSP_S_BWD: begin
        step_bwd = hold_over;
      end
      default: begin
        step_fwd = 1'b0;
        step_bwd = 1'b0;
      end
    endcase
  end

  // motor state: homing after reset, then track the target
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_state      <= PSP_S_HOME;
      home_left        <= HOME_STEPS;
      current_position <= START_POS;
      homing_done      <= 1'b0;
    end else begin
      case (motor_state)
        PSP_S_HOME: begin
          if (step_bwd) begin
            home_left <= home_left - 7'h01;
          end else if (home_left == START_POS && hold_over) begin
            current_position <= START_POS;
            homing_done      <= 1'b1;
            motor_state      <= PSP_S_IDLE;
          end
        end
        PSP_S_IDLE, PSP_S_FWD, PSP_S_BWD: begin
          if (step_fwd) begin
            current_position <= current_position + 7'h01;
          end else if (step_bwd) begin
            current_position <= current_position - 7'h01;
          end
          if (required_position > current_position) begin
            motor_state <= PSP_S_FWD;
          end else if (required_position < current_position) begin
            motor_state <= PSP_S_BWD;
          end else begin
            motor_state <= PSP_S_IDLE;
          end
          // re-decide after each step so no step overshoots
          if (step_fwd || step_bwd) begin
            motor_state <= PSP_S_IDLE;
          end
        end
        default: begin
          motor_state <= PSP_S_HOME;
        end
      endcase
    end
  end

  // coil sequence index: up is forward, down is backward
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coil_idx <= IDX_RESET;
    end else if (step_fwd) begin
      coil_idx <= coil_idx + 2'h1;
    end else if (step_bwd) begin
      coil_idx <= coil_idx - 2'h1;
    end
  end

  // pattern lookup; coils A and B alternate from one entry to the next
  always_comb begin
    case (coil_idx)
      2'h0:    next_pattern = COIL_PAT0;
      2'h1:    next_pattern = COIL_PAT1;
      2'h2:    next_pattern = COIL_PAT2;
      2'h3:    next_pattern = COIL_PAT3;
      default: next_pattern = COIL_PAT0;
    endcase
  end

  // registered coil port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coil_port <= COIL_PAT0;
    end else begin
      coil_port <= next_pattern;
    end
  end

  // port bits to terminals
  assign winding_a_pos = coil_port[BIT_A_POS];
  assign winding_a_neg = coil_port[BIT_A_NEG];
  assign winding_b_pos = coil_port[BIT_B_POS];
  assign winding_b_neg = coil_port[BIT_B_NEG];

  // positions 0..100 cover the full range
endmodule

// file: verification/psp_positioner_sva.sv
/* port checks of the positioner.
   assumes a bind into psp_positioner and one clock. */
module psp_chk
  import psp_pkg::*;
(
  // clock, reset, pin
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       capture_pin,
  input wire logic [psp_pkg::HOLD_W-1:0] step_hold,
  // coils
  input wire logic                       winding_a_pos,
  input wire logic                       winding_a_neg,
  input wire logic                       winding_b_pos,
  input wire logic                       winding_b_neg,
  // status
  input wire logic [psp_pkg::POS_W-1:0]  current_position,
  input wire logic [psp_pkg::POS_W-1:0]  required_position,
  input wire logic [psp_pkg::CNT_W-1:0]  period_value,
  input wire logic [psp_pkg::CNT_W-1:0]  high_value,
  input wire logic                       homing_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import psp_pkg::*;
  logic [3:0]  coil;
  logic [7:0]  hcnt;
  logic [15:0] gap;
  logic        seen;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // coil nibble, bit 0 first
  assign coil = {winding_b_neg, winding_b_pos, winding_a_neg, winding_a_pos};
  // homing change count, cycles since last change
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hcnt <= 8'h00;
      gap <= 16'h0000;
      seen <= 1'b0;
    end else if (coil != $past(coil)) begin
      hcnt <= homing_done ? hcnt : hcnt + 8'h01;
      gap <= 16'h0001;
      seen <= 1'b1;
    end else begin
      gap <= gap + 16'h0001;
    end
  end
  coil_polar_a: assert property (winding_a_pos != winding_a_neg && winding_b_pos != winding_b_neg)
    else $error("coil pair shorted");
  coil_alt_a: assert property (coil != $past(coil) |-> (coil[1:0] != $past(coil[1:0])) != (coil[3:2] != $past(coil[3:2])))
    else $error("both coils changed");
  pos_step_a: assert property (homing_done && $past(homing_done) && current_position != $past(current_position) |-> current_position - $past(current_position) inside {7'h01, 7'h7F})
    else $error("position jumped");
  fwd_dir_a: assert property (homing_done && $past(homing_done) && current_position == $past(current_position) + 7'h01 |-> required_position >= current_position)
    else $error("forward past target");
  bwd_dir_a: assert property (homing_done && $past(homing_done) && current_position + 7'h01 == $past(current_position) |-> required_position <= current_position)
    else $error("backward past target");
  home_zero_a: assert property ($rose(homing_done) |-> current_position == START_POS && hcnt inside {8'h63, 8'h64})
    else $error("homing count wrong");
  duty_calc_a: assert property ($changed(required_position) |-> 31'(required_position) == 31'(high_value) * 31'h64 / 31'(period_value) && required_position <= POS_MAX)
    else $error("target not duty");
  edge_pt_a: assert property ($changed(period_value) |-> capture_pin ##0 !$changed(high_value))
    else $error("period latched off edge");
  hold_gap_a: assert property (seen && coil != $past(coil) |-> gap >= ((step_hold == 16'h0000) ? 16'h0001 : step_hold))
    else $error("coil change too soon");
endmodule

bind psp_positioner psp_chk u_chk (.clk_sys, .rst_n, .capture_pin, .step_hold, .winding_a_pos,
  .winding_a_neg, .winding_b_pos, .winding_b_neg, .current_position, .required_position,
  .period_value, .high_value, .homing_done);

// file: verification/psp_far_side.sv
/* far side: pwm source of 1001-cycle frames and a stepper with a hard stop at zero.
   assumes duty is held within 1..99. */
module psp_far_side (
  // clock and pwm
  input  wire logic       clk_sys,
  input  wire logic [6:0] duty,
  output logic            capture_pin,
  // coils
  input  wire logic       winding_a_pos,
  input  wire logic       winding_a_neg,
  input  wire logic       winding_b_pos,
  input  wire logic       winding_b_neg,
  // rotor
  output int              mech_pos,
  output logic            step_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ph;
  logic [9:0] hi;
  logic [3:0] last;
  logic [3:0] coil;
  // next pattern on the forward walk
  function automatic logic [3:0] nxt(input logic [3:0] p);
    case (p)
      4'hA: return 4'h9;
      4'h9: return 4'h5;
      4'h5: return 4'h6;
      default: return 4'hA;
    endcase
  endfunction
  assign coil = {winding_b_neg, winding_b_pos, winding_a_neg, winding_a_pos};
  // rotor left mid-travel at power-up
  initial begin
    ph = 10'h000;
    hi = 10'h00B;
    last = 4'hA;
    capture_pin = 1'b0;
    mech_pos = 37;
    step_err = 1'b0;
  end
  // frame high for 10*duty+1 cycles, duty taken at frame start
  always @(posedge clk_sys) begin
    ph <= (ph == 10'h3E8) ? 10'h000 : ph + 10'h001;
    if (ph == 10'h000) hi <= 10'(duty) * 10'h00A + 10'h001;
    capture_pin <= (ph < hi);
  end
  // one pattern forward or back is one rotor step
  always @(posedge clk_sys) begin
    last <= coil;
    if (coil != last && coil == nxt(last))
      mech_pos <= mech_pos + 1;
    else if (coil != last && last == nxt(coil))
      mech_pos <= (mech_pos > 0) ? mech_pos - 1 : 0;
    else if (coil != last)
      step_err <= 1'b1;
  end
endmodule

// file: verification/tb_pwm_duty_stepper_positioner.sv
/* bench: homes the motor, then walks it through random duties.
   assumes the far-side model makes the pin and follows the coils. */
module tb_pwm_duty_stepper_positioner;
  timeunit 1ns;
  timeprecision 1ps;
  import psp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [HOLD_W-1:0] step_hold = 16'h0002;
  logic [6:0]        duty = 7'h32;
  logic [6:0]        d;
  logic [POS_W-1:0]  current_position, required_position;
  logic [POS_W-1:0]  prev_req = 7'h00;
  logic              capture_pin, homing_done, duty_valid, step_err;
  logic              winding_a_pos, winding_a_neg, winding_b_pos, winding_b_neg;
  logic [31:0]       rs = 32'h0000_3952;
  logic [6:0]        expq[$];
  int                mech_pos;
  int                err_count = 0;
  int                num_checks = 0;

  psp_positioner DUT (.clk_sys, .rst_n, .capture_pin, .step_hold, .winding_a_pos,
    .winding_a_neg, .winding_b_pos, .winding_b_neg, .current_position,
    .required_position, .period_value(), .high_value(), .homing_done, .duty_valid);
  psp_far_side u_far (.clk_sys, .duty, .capture_pin, .winding_a_pos, .winding_a_neg,
    .winding_b_pos, .winding_b_neg, .mech_pos, .step_err);

  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input logic [6:0] got, input logic [6:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // oldest noted target taken off whenever the target moves
  always @(posedge clk_sys) begin
    if (rst_n && required_position !== prev_req)
      check(required_position, expq.size() ? expq.pop_front() : 7'h7F, "target");
    prev_req <= required_position;
  end

  // reset, homing, then duty steps incl. both extremes
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 2000 && homing_done !== 1'b1; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(current_position, START_POS, "home");
    check(7'(mech_pos), START_POS, "stop");
    check({6'h00, duty_valid}, 7'h00, "early valid");
    $display("test homing done");
    for (int t = 0; t < 10; t++) begin
      rs = xs(rs);
      d = (t == 0) ? 7'h63 : (t == 1) ? 7'h01 : 7'(rs % 99 + 1);
      if (d === required_position)
        d = (d == 7'h63) ? 7'h01 : d + 7'h01;
      step_hold <= 16'(rs[20:18]);
      duty <= d;
      expq.push_back(d);
      for (int i = 0; i < 6000 && expq.size() > 0; i++) @(posedge clk_sys);
      for (int i = 0; i < 2000 && current_position !== d; i++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      check(current_position, d, "position");
      check({6'h00, duty_valid}, 7'h01, "valid");
      check(7'(mech_pos), d, "rotor");
      check({6'h00, step_err}, 7'h00, "coil order");
      $display("test duty %0d done", d);
    end
    summarize();
  end

  // cuts a hang short
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
